// >>> src/bas_pkg.sv
// ********************************************************
// brake and auxiliary sequencer: shared definitions
// ********************************************************
package bas_pkg;
  // register byte offsets
  localparam logic [7:0] BAS_OFS_CTRL = 8'h00;
  localparam logic [7:0] BAS_OFS_REL = 8'h04;
  localparam logic [7:0] BAS_OFS_CLOSE = 8'h08;
  localparam logic [7:0] BAS_OFS_RAMP = 8'h0c;
  localparam logic [7:0] BAS_OFS_AUXON = 8'h10;
  localparam logic [7:0] BAS_OFS_AUXOFF = 8'h14;
  localparam logic [7:0] BAS_OFS_STAT = 8'h18;
  // control register fields
  localparam int BAS_TYPE_LSB = 0;
  localparam int BAS_OPT_LSB = 8;
  // brake type codes
  localparam logic [1:0] BAS_BRK_NONE = 2'h0;
  localparam logic [1:0] BAS_BRK_HOLD = 2'h1;
  localparam logic [1:0] BAS_BRK_OPER = 2'h2;
  // optimization run codes that force the brake closed
  localparam logic [7:0] BAS_OPT_PRECTRL = 8'h18;
  localparam logic [7:0] BAS_OPT_CURCTRL = 8'h19;
  // values after reset
  localparam logic [1:0] BAS_RST_TYPE = 2'h0;
  localparam logic [7:0] BAS_RST_OPT = 8'h00;
  localparam logic [15:0] BAS_RST_TIME = 16'h0000;
  // delay unit: one tick per millisecond
  localparam int BAS_CLK_FREQ_HZ = 50000000;
  localparam int BAS_TICK_TIME_US = 1000;
  localparam int BAS_TICK_CYCLES = BAS_CLK_FREQ_HZ / 1000000 * BAS_TICK_TIME_US;
  // command pins, all active high
  typedef struct packed {
    logic switch_on_terminal;
    logic operation_enable_terminal;
    logic jog;
    logic creep;
    logic quick_stop;
    logic disconnection;
    logic emergency_stop;
    logic speed_below_min;
  } bas_cmd_type;
  // actuator outputs
  typedef struct packed {
    logic brake_close_request;
    logic auxiliaries_on_request;
    logic line_contactor_close;
    logic firing_pulse_enable;
    logic setpoint_zero_hold;
    logic auxiliary_wait_state;
  } bas_out_type;
endpackage

// >>> src/bas_timer.sv
`timescale 1ns/100ps
// ********************************************************
// delay timer counting millisecond ticks
// ********************************************************
module bas_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic start,
  input wire logic tick,
  input wire logic [15:0] len,
  // status
  output logic done
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // load on start, count down on each tick
  always_comb begin
    if (start) begin
      cnt_d = len;
    end else if (tick && cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
    end else begin
      cnt_d = cnt_q;
    end
    done = (cnt_q == 16'h0000) && !start;
  end

  // counter register, cleared by reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // bas_timer

// >>> src/bas_sequencer.sv
`timescale 1ns/100ps
// What this block does
// - brake_close_request high asks to close the brake, low asks to open it.
// - brake type 0 means no brake, 1 a holding brake, 2 an operational brake, and it governs closing.
// - with a holding brake and no optimization code the close request is given only while speed is below minimum.
// - with an operational brake the close request is given even while the motor still turns.
// - a positive release time keeps torque off after the brake opens until that time has passed.
// - a negative release time starts torque that much before the brake opens.
// - after a close request on loss of operation enable torque stays on for the brake closing time.
// - after torque comes on the setpoint is held at zero for the ramp enable delay.
// - jog, creep and quick stop act on the brake like switch on and switch off.
// - disconnection and emergency stop act like removing operation enable.
// - optimization codes 24 and 25 force the close request.
// - auxiliaries turn on with the switch on command, and 0 means off.
// - after switch on the block waits the auxiliary on delay before closing the line contactor.
// - switch off kills firing pulses at once and the contactor opens once speed is below minimum.
// - after switch off the auxiliaries stay on for the auxiliary off delay, then go to 0.
// - switch on during the auxiliary off delay closes the contactor without the wait.
module bas_sequencer
  import bas_pkg::*;
#(
  parameter int TICK_CYCLES = BAS_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // command pins
  input wire bas_pkg::bas_cmd_type cmd_pins,
  // actuator outputs
  output bas_pkg::bas_out_type act
);
  import bas_pkg::*;

  typedef enum logic [1:0] {S_OFF, S_AUXWAIT, S_ON, S_STOP} bas_sup_type;
  typedef enum logic [2:0] {B_IDLE, B_PRE, B_REL, B_RUN, B_WAITN, B_CLOSE} bas_brk_type;

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  bas_cmd_type sync1_q, sync2_q;

  // two flops before any logic looks at a pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= cmd_pins;
      sync2_q <= sync1_q;
    end
  end

  logic on_cmd, enable, speed_low;
  // command merging for sequencing
  assign on_cmd = (sync2_q.switch_on_terminal | sync2_q.jog | sync2_q.creep) & ~sync2_q.quick_stop;
  assign enable = sync2_q.operation_enable_terminal & ~sync2_q.disconnection & ~sync2_q.emergency_stop;
  assign speed_low = sync2_q.speed_below_min;

  // ********************************************************
  // register file over ahb-lite
  // ********************************************************
  logic [1:0] type_q, type_d;
  logic [7:0] opt_q, opt_d;
  logic [15:0] rel_q, rel_d, close_q, close_d, ramp_q, ramp_d;
  logic [15:0] auxon_q, auxon_d, auxoff_q, auxoff_d;
  logic wr_q, wr_d;
  logic [7:0] wa_q, wa_d;
  logic [31:0] rd_q, rd_d;
  logic aphase;
  bas_out_type out_q, out_d;

  assign aphase = hsel && htrans[1] && hready;

  // decode, write in data phase, read data staged at address phase
  always_comb begin
    type_d = type_q;
    opt_d = opt_q;
    rel_d = rel_q;
    close_d = close_q;
    ramp_d = ramp_q;
    auxon_d = auxon_q;
    auxoff_d = auxoff_q;
    wr_d = aphase && hwrite;
    wa_d = aphase ? haddr[7:0] : wa_q;
    rd_d = rd_q;
    if (wr_q && hready) begin
      unique case (wa_q)
        BAS_OFS_CTRL: begin
          type_d = hwdata[BAS_TYPE_LSB +: 2];
          opt_d = hwdata[BAS_OPT_LSB +: 8];
        end
        BAS_OFS_REL: rel_d = hwdata[15:0];
        BAS_OFS_CLOSE: close_d = hwdata[15:0];
        BAS_OFS_RAMP: ramp_d = hwdata[15:0];
        BAS_OFS_AUXON: auxon_d = hwdata[15:0];
        BAS_OFS_AUXOFF: auxoff_d = hwdata[15:0];
        default: ; // status and unmapped writes are ignored
      endcase
    end
    if (aphase && !hwrite) begin
      unique case (haddr[7:0])
        BAS_OFS_CTRL: rd_d = {16'h0000, opt_q, 6'h00, type_q};
        BAS_OFS_REL: rd_d = {16'h0000, rel_q};
        BAS_OFS_CLOSE: rd_d = {16'h0000, close_q};
        BAS_OFS_RAMP: rd_d = {16'h0000, ramp_q};
        BAS_OFS_AUXON: rd_d = {16'h0000, auxon_q};
        BAS_OFS_AUXOFF: rd_d = {16'h0000, auxoff_q};
        BAS_OFS_STAT: rd_d = {24'h000000, ~on_cmd, enable, out_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // register file state, zero wait states, always okay
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      type_q <= BAS_RST_TYPE;
      opt_q <= BAS_RST_OPT;
      rel_q <= BAS_RST_TIME;
      close_q <= BAS_RST_TIME;
      ramp_q <= BAS_RST_TIME;
      auxon_q <= BAS_RST_TIME;
      auxoff_q <= BAS_RST_TIME;
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      rd_q <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      type_q <= type_d;
      opt_q <= opt_d;
      rel_q <= rel_d;
      close_q <= close_d;
      ramp_q <= ramp_d;
      auxon_q <= auxon_d;
      auxoff_q <= auxoff_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
      rd_q <= rd_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign hrdata = rd_q;

  // ********************************************************
  // millisecond tick and delay timers
  // ********************************************************
  logic [15:0] pre_q, pre_d;
  logic tick;

  // free running prescaler, so each delay may run up to one tick short
  always_comb begin
    tick = (pre_q == 16'(TICK_CYCLES - 1));
    pre_d = tick ? 16'h0000 : pre_q + 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_d;
    end
  end

  logic auxon_start, auxon_done, auxoff_start, auxoff_done;
  logic brk_start, brk_done, ramp_start, ramp_done;
  logic [15:0] brk_len;

  // timers reset with the block
  bas_timer u_auxon (.clk(clk), .rst_b(rst_b), .start(auxon_start), .tick(tick), .len(auxon_q),
                     .done(auxon_done));
  bas_timer u_auxoff (.clk(clk), .rst_b(rst_b), .start(auxoff_start), .tick(tick), .len(auxoff_q),
                      .done(auxoff_done));
  bas_timer u_brk (.clk(clk), .rst_b(rst_b), .start(brk_start), .tick(tick), .len(brk_len),
                   .done(brk_done));
  bas_timer u_ramp (.clk(clk), .rst_b(rst_b), .start(ramp_start), .tick(tick), .len(ramp_q),
                    .done(ramp_done));

  // ********************************************************
  // supply sequencing: auxiliaries and line contactor
  // ********************************************************
  bas_sup_type sup_q, sup_d;
  logic on_prev_q, offrun_q, offrun_d, aux_d;

  always_comb begin
    sup_d = sup_q;
    auxon_start = 1'b0;
    auxoff_start = !on_cmd && on_prev_q;
    aux_d = out_q.auxiliaries_on_request;
    offrun_d = offrun_q;
    if (on_cmd) begin
      aux_d = 1'b1;
      offrun_d = 1'b0;
    end else if (auxoff_start) begin
      offrun_d = 1'b1;
    end else if (offrun_q && auxoff_done) begin
      aux_d = 1'b0;
      offrun_d = 1'b0;
    end
    unique case (sup_q)
      S_OFF: begin
        if (on_cmd && out_q.auxiliaries_on_request) begin
          sup_d = S_ON;
        end else if (on_cmd) begin
          sup_d = S_AUXWAIT;
          auxon_start = 1'b1;
        end
      end
      S_AUXWAIT: begin
        if (!on_cmd) begin
          sup_d = S_OFF;
        end else if (auxon_done) begin
          sup_d = S_ON;
        end
      end
      S_ON: begin
        if (!on_cmd) begin
          sup_d = S_STOP;
        end
      end
      S_STOP: begin
        if (on_cmd) begin
          sup_d = S_ON;
        end else if (speed_low) begin
          sup_d = S_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sup_q <= S_OFF;
      on_prev_q <= 1'b0;
      offrun_q <= 1'b0;
    end else begin
      sup_q <= sup_d;
      on_prev_q <= on_cmd;
      offrun_q <= offrun_d;
    end
  end

  // ********************************************************
  // brake and torque sequencing
  // ********************************************************
  bas_brk_type brk_q, brk_d;
  logic run_en, rel_neg, opt_force;
  logic [15:0] rel_mag;

  // a switch off seen while the supply is still on must not start a new release
  assign run_en = (sup_q == S_ON) && on_cmd && enable;
  assign rel_neg = rel_q[15];
  assign rel_mag = rel_neg ? (~rel_q + 16'h0001) : rel_q;
  assign opt_force = (opt_q == BAS_OPT_PRECTRL) || (opt_q == BAS_OPT_CURCTRL);

  always_comb begin
    brk_d = brk_q;
    brk_start = 1'b0;
    brk_len = close_q;
    unique case (brk_q)
      B_IDLE: begin
        if (run_en) begin
          brk_start = 1'b1;
          brk_len = rel_mag;
          brk_d = rel_neg ? B_PRE : B_REL;
        end
      end
      B_PRE: begin
        if (!on_cmd) begin
          brk_d = B_IDLE;
        end else if (!enable) begin
          brk_d = B_CLOSE;
          brk_start = 1'b1;
        end else if (brk_done) begin
          brk_d = B_RUN;
        end
      end
      B_REL: begin
        if (!run_en) begin
          brk_d = B_IDLE;
        end else if (brk_done) begin
          brk_d = B_RUN;
        end
      end
      B_RUN: begin
        if (!on_cmd) begin
          brk_d = B_IDLE;
        end else if (!enable && type_q == BAS_BRK_HOLD) begin
          brk_d = B_WAITN;
        end else if (!enable) begin
          brk_d = B_CLOSE;
          brk_start = 1'b1;
        end
      end
      B_WAITN: begin
        if (!on_cmd) begin
          brk_d = B_IDLE;
        end else if (speed_low) begin
          brk_d = B_CLOSE;
          brk_start = 1'b1;
        end
      end
      B_CLOSE: begin
        if (!on_cmd || brk_done) begin
          brk_d = B_IDLE;
        end
      end
      default: brk_d = B_IDLE;
    endcase
    // ramp delay starts when torque comes on
    ramp_start = (brk_d == B_PRE && brk_q != B_PRE) || (brk_d == B_RUN && brk_q == B_REL);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      brk_q <= B_IDLE;
    end else begin
      brk_q <= brk_d;
    end
  end

  // ********************************************************
  // actuator outputs
  // ********************************************************
  always_comb begin
    out_d.auxiliaries_on_request = aux_d;
    out_d.line_contactor_close = (sup_d == S_ON) || (sup_d == S_STOP);
    out_d.auxiliary_wait_state = (sup_d == S_AUXWAIT);
    out_d.firing_pulse_enable = (brk_d == B_PRE) || (brk_d == B_RUN) || (brk_d == B_WAITN)
                                || (brk_d == B_CLOSE);
    out_d.setpoint_zero_hold = !(brk_d == B_RUN && !ramp_start && ramp_done);
    unique case (brk_d)
      B_IDLE: out_d.brake_close_request = (type_q == BAS_BRK_OPER) || (type_q == BAS_BRK_HOLD);
      B_PRE, B_CLOSE: out_d.brake_close_request = 1'b1;
      default: out_d.brake_close_request = 1'b0;
    endcase
    // without an optimization code, no brake never closes and a holding brake waits for low speed
    if (type_q == BAS_BRK_NONE || (type_q == BAS_BRK_HOLD && !speed_low)) begin
      out_d.brake_close_request = 1'b0;
    end
    if (opt_force) begin
      out_d.brake_close_request = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= '{setpoint_zero_hold: 1'b1, default: 1'b0};
    end else begin
      out_q <= out_d;
    end
  end
  assign act = out_q;

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_no_brake;
    out_q.brake_close_request |-> $past(type_q) != BAS_BRK_NONE || $past(opt_force);
  endproperty
  a_no_brake: assert property (p_no_brake) else $error("close request with no brake");

  property p_hold_low;
    out_q.brake_close_request && $past(type_q) == BAS_BRK_HOLD && !$past(opt_force) |-> $past(speed_low);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("holding brake closed above minimum speed");

  property p_oper_idle;
    brk_q == B_IDLE && brk_d == B_IDLE && type_q == BAS_BRK_OPER |=> out_q.brake_close_request;
  endproperty
  a_oper_idle: assert property (p_oper_idle) else $error("operational brake not closed");

  property p_rel_pos;
    brk_q == B_REL |-> !out_q.firing_pulse_enable;
  endproperty
  a_rel_pos: assert property (p_rel_pos) else $error("torque during brake release");

  property p_rel_neg;
    brk_q == B_PRE && $past(type_q) != BAS_BRK_NONE && ($past(type_q) == BAS_BRK_OPER || $past(speed_low)) |->
      out_q.firing_pulse_enable && out_q.brake_close_request;
  endproperty
  a_rel_neg: assert property (p_rel_neg) else $error("no torque against closed brake");

  property p_closing;
    brk_q == B_CLOSE |-> out_q.firing_pulse_enable;
  endproperty
  a_closing: assert property (p_closing) else $error("torque dropped while closing");

  property p_ramp;
    $fell(out_q.setpoint_zero_hold) |-> $past(ramp_done) && $past(brk_d) == B_RUN;
  endproperty
  a_ramp: assert property (p_ramp) else $error("setpoint released early");

  property p_opt;
    opt_force |=> out_q.brake_close_request;
  endproperty
  a_opt: assert property (p_opt) else $error("optimization run without close");

  property p_aux_on;
    on_cmd |=> out_q.auxiliaries_on_request;
  endproperty
  a_aux_on: assert property (p_aux_on) else $error("auxiliaries not on");

  property p_cont_wait;
    $rose(out_q.line_contactor_close) && $past(sup_q) == S_AUXWAIT |-> $past(auxon_done);
  endproperty
  a_cont_wait: assert property (p_cont_wait) else $error("contactor before auxiliary delay");

  property p_off_pulses;
    !on_cmd |=> !out_q.firing_pulse_enable && (!$fell(out_q.line_contactor_close) || $past(speed_low));
  endproperty
  a_off_pulses: assert property (p_off_pulses) else $error("switch off sequence broken");

  property p_aux_off;
    $fell(out_q.auxiliaries_on_request) |-> $past(auxoff_done) && !$past(on_cmd);
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("auxiliaries off early");

  property p_skip_wait;
    sup_q == S_OFF && on_cmd && out_q.auxiliaries_on_request |=> out_q.line_contactor_close;
  endproperty
  a_skip_wait: assert property (p_skip_wait) else $error("auxiliary wait not skipped");

  c_run: cover property (brk_q == B_REL ##1 brk_q == B_RUN);
  c_pre: cover property (brk_q == B_PRE ##1 brk_q == B_RUN);
  c_close: cover property (brk_q == B_CLOSE ##1 brk_q == B_IDLE);
  c_skip: cover property (sup_q == S_STOP ##1 sup_q == S_ON);
endmodule // bas_sequencer

// >>> sim/bas_motor_model.sv
`timescale 1ns/100ps
// ********************************************************
// motor and brake seen from the actuator side
// ********************************************************
module bas_motor_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // actuator commands and bench load demand
  input wire bas_pkg::bas_out_type act,
  input wire logic spin,
  // speed feedback
  output logic speed_below_min
);
  import bas_pkg::*;
  logic [5:0] speed_q;
  logic [5:0] speed_d;
  // speed rises only with torque on an open brake, holds with torque on a closed brake, else coasts down
  always_comb begin
    speed_d = speed_q;
    if (spin && act.firing_pulse_enable && !act.brake_close_request && speed_q != 6'h28) begin
      speed_d = speed_q + 6'h01;
    end else if (!(spin && act.firing_pulse_enable) && speed_q != 6'h00) begin
      speed_d = speed_q - 6'h01;
    end
  end
  // standstill after reset, slow decay so the coast phase is visible
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_q <= 6'h00;
    end else begin
      speed_q <= speed_d;
    end
  end
  assign speed_below_min = (speed_q < 6'h04);
endmodule // bas_motor_model

// >>> sim/tb_bas_sequencer.sv
`timescale 1ns/100ps
// ********************************************************
// self-checking bench for the brake and auxiliary sequencer
// ********************************************************
module tb_bas_sequencer;
  import bas_pkg::*;
  // pin positions inside pins_q
  localparam int SO = 6;
  localparam int EN = 5;
  localparam int JG = 4;
  localparam int QS = 2;
  localparam int DC = 1;
  localparam int ES = 0;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [6:0] pins_q = 7'h00;
  logic spin = 1'b0;
  logic slow;
  logic rd_ph = 1'b0;
  logic [31:0] v;
  logic [63:0] chk;
  logic [63:0] exp_q[$];
  bas_out_type act;
  bas_cmd_type cmd;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 32'h2fa3;
  always #10 clk = ~clk;
  // speed feedback comes from the motor model, the rest from the bench
  assign cmd = {pins_q, slow};
  // short ticks of 4 cycles each keep the delays to at most 120 cycles
  bas_sequencer #(.TICK_CYCLES(4)) bas_sequencer_i (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmd_pins(cmd), .act(act));
  bas_motor_model bas_motor_model_i (.clk(clk), .rst_b(rst_b), .act(act), .spin(spin), .speed_below_min(slow));
  // ********************************************************
  // bus tasks
  // ********************************************************
  // one single transfer; reads note the masked expectation
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr) exp_q.push_back({m, e});
    rd_ph <= !wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd_ph <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 32'h0, 32'h0);
  endtask
  // wait n cycles, then read the status word
  task st(input int n, input logic [31:0] m, input logic [31:0] e);
    repeat (n) @(posedge clk);
    ahb(1'b0, BAS_OFS_STAT, 32'h0, m, e);
  endtask
  task end_of_test;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // read data is taken at the end edge of the data phase
  always @(posedge clk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      chk = exp_q.pop_front();
      n_compared++;
      if (hresp !== 1'b0 || (hrdata & chk[63:32]) !== chk[31:0]) begin
        error_cnt++;
        $display("FAIL %0t read %h expected %h mask %h", $time, hrdata, chk[31:0], chk[63:32]);
      end
    end
  end
  // hang guard, far beyond the roughly 760 cycles of the sequence
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("FAIL %0t watchdog expired", $time);
    end_of_test;
  end
  // ********************************************************
  // scenarios
  // ********************************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, unmapped word included
    for (int i = 0; i < 8; i++) begin
      ahb(1'b0, 8'(4 * i), 32'h0, 32'hffffffff, (i == 6) ? 32'h82 : 32'h0);
    end
    // random delays read back in their low half
    for (int i = 1; i < 6; i++) begin
      v = $random(seed);
      wr(8'(4 * i), v);
      ahb(1'b0, 8'(4 * i), 32'h0, 32'hffffffff, {16'h0, v[15:0]});
    end
    v = $random(seed);
    v[1:0] = BAS_BRK_OPER;
    wr(BAS_OFS_CTRL, v);
    ahb(1'b0, BAS_OFS_CTRL, 32'h0, 32'hffffffff, {16'h0, v[15:8], 6'h0, v[1:0]});
    // idle brake state for each type at standstill
    for (int i = 0; i < 3; i++) begin
      wr(BAS_OFS_CTRL, 32'(i));
      st(2, 32'h20, (i == 0) ? 32'h0 : 32'h20);
    end
    // optimization codes force the brake closed, a neighbour does not
    wr(BAS_OFS_CTRL, {16'h0, BAS_OPT_PRECTRL, 8'h00});
    st(2, 32'h20, 32'h20);
    wr(BAS_OFS_CTRL, {16'h0, BAS_OPT_CURCTRL, 8'h00});
    st(2, 32'h20, 32'h20);
    wr(BAS_OFS_CTRL, 32'h1700);
    st(2, 32'h20, 32'h0);
    // delays in ticks, chosen so every phase can be seen
    wr(BAS_OFS_CTRL, {30'h0, BAS_BRK_OPER});
    wr(BAS_OFS_REL, 32'h4);
    wr(BAS_OFS_CLOSE, 32'h4);
    wr(BAS_OFS_RAMP, 32'ha);
    wr(BAS_OFS_AUXON, 32'h3);
    wr(BAS_OFS_AUXOFF, 32'h1e);
    // switch on: auxiliaries at once, contactor after the on delay
    pins_q[SO] <= 1'b1;
    st(5, 32'h19, 32'h11);
    st(20, 32'h19, 32'h18);
    // enable: brake opens, torque after release time, then ramp
    pins_q[EN] <= 1'b1;
    spin <= 1'b1;
    st(5, 32'h26, 32'h02);
    st(20, 32'h06, 32'h06);
    st(40, 32'h02, 32'h0);
    // emergency stop acts like enable withdrawal
    pins_q[ES] <= 1'b1;
    st(5, 32'h24, 32'h24);
    st(20, 32'h04, 32'h0);
    // negative release: torque against the still closed brake
    wr(BAS_OFS_REL, 32'hfffc);
    pins_q[ES] <= 1'b0;
    st(5, 32'h24, 32'h24);
    st(20, 32'h20, 32'h0);
    // holding brake: coast down, close only below minimum speed
    repeat (60) @(posedge clk);
    wr(BAS_OFS_CTRL, {30'h0, BAS_BRK_HOLD});
    pins_q[DC] <= 1'b1;
    spin <= 1'b0;
    st(5, 32'h24, 32'h04);
    st(60, 32'h24, 32'h20);
    // run up again, then quick stop while turning
    wr(BAS_OFS_REL, 32'h0);
    pins_q[DC] <= 1'b0;
    spin <= 1'b1;
    repeat (80) @(posedge clk);
    pins_q[QS] <= 1'b1;
    spin <= 1'b0;
    st(5, 32'h1c, 32'h18);
    st(60, 32'h08, 32'h0);
    // switch on inside the off delay skips the auxiliary wait
    wr(BAS_OFS_AUXON, 32'h14);
    pins_q[QS] <= 1'b0;
    st(6, 32'h19, 32'h18);
    // plain switch off: auxiliaries linger for the off delay
    pins_q[SO] <= 1'b0;
    st(40, 32'h10, 32'h10);
    st(100, 32'h10, 32'h0);
    // jog alone switches the auxiliaries on
    pins_q[JG] <= 1'b1;
    st(5, 32'h11, 32'h11);
    end_of_test;
  end
endmodule // tb_bas_sequencer
